// [design/lpm_pkg.sv]
// Constants for the codeword link pin mapping block
package lpm_pkg;
    // Widths and depths
    localparam int unsigned CODEWORD_W = 10;
    localparam int unsigned CONN_W = 32;
    localparam int unsigned IDX_W = 5;
    localparam int unsigned ADDR_W = 8;
    localparam int unsigned ENTRY_W = 16;
    localparam int unsigned TBL_DEPTH = 1024;
    localparam int unsigned COUNT_W = 16;
    // Register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_PIN_SEL = 8'h04;
    localparam logic [7:0] ADDR_CODE_MASK = 8'h08;
    localparam logic [7:0] ADDR_CODE_SHIFT = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_TBL_ADDR = 8'h14;
    localparam logic [7:0] ADDR_TBL_DATA = 8'h18;
    // Control bits
    localparam int unsigned CTRL_RX_EN = 0;
    localparam int unsigned CTRL_TX_EN = 1;
    localparam int unsigned CTRL_PLAY_ARM = 2;
    localparam int unsigned CTRL_W = 3;
    // Field positions
    localparam int unsigned PIN_SEL_STROBE_LSB = 0;
    localparam int unsigned PIN_SEL_VALID_LSB = 8;
    localparam int unsigned STATUS_COUNT_LSB = 16;
    // Reset values
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [4:0] STROBE_IDX_RST = 5'h0f;
    localparam logic [4:0] VALID_IDX_RST = 5'h00;
    localparam logic [31:0] CODE_MASK_RST = 32'h0000_07fe;
    localparam logic [4:0] CODE_SHIFT_RST = 5'h01;
    // Fixed transmit pin map
    localparam int unsigned PIN_VALID_A = 0;
    localparam int unsigned PIN_RESULT_LSB = 1;
    localparam int unsigned PIN_RESULT_MSB = 10;
    localparam int unsigned PIN_RSV_LSB = 11;
    localparam int unsigned PIN_RSV_MSB = 13;
    localparam int unsigned PIN_VALID_B = 14;
    localparam int unsigned PIN_STROBE = 15;
    localparam logic [31:0] TX_OE_MASK = 32'h0000_ffff;
    // Strobe timing
    localparam longint LINK_HZ = 50_000_000;
    localparam longint STROBE_HZ = 25_000_000;
    localparam int unsigned STROBE_HALF = ((LINK_HZ / (2 * STROBE_HZ)) < 1) ? 1 : int'(LINK_HZ / (2 * STROBE_HZ));
endpackage

// [design/lpm_top.sv]
// Codeword link receive and transmit mapping onto the general I/O connector
// Function
// - Strobe and valid inputs come from connector pins chosen by software indices.
// - Codeword is connector word masked and right shifted, at most 10 bits.
// - Codeword indexes the waveform table for indexed playback.
// - Transmit side uses fixed pins, all driven as outputs.
// - Valid flag driven on connector bit 0 and copied on bit 14.
// - Ten readout results placed on connector bits 10 down to 1.
// - Connector bits 13 down to 11 are reserved outputs, driven low.
// - Connector bit 15 carries a free running 25 MHz toggling strobe.
// - Back to back codewords on consecutive slots are accepted.
`timescale 1ns/10ps
`default_nettype none
module lpm_top
#(
    parameter int unsigned TBL_DEPTH = lpm_pkg::TBL_DEPTH
)
(
    // Core clock and reset
    input wire logic I_CORE_CLK,
    input wire logic I_RSTN,
    // Link clock
    input wire logic I_LINK_CLK,
    // Register port
    input wire logic [7:0] I_ADDR,
    input wire logic [31:0] I_WDATA,
    input wire logic I_WR,
    input wire logic I_RD,
    output logic [31:0] O_RDATA,
    // Connector pins
    input wire logic [31:0] I_CONN_IN,
    output logic [31:0] O_CONN_OUT,
    output logic [31:0] O_CONN_OE,
    // Readout results to transmit
    input wire logic I_READOUT_VALID,
    input wire logic [9:0] I_READOUT_RESULT,
    // Indexed playback request
    output logic O_WAVE_PLAY,
    output logic [9:0] O_WAVE_INDEX,
    output logic [15:0] O_WAVE_ENTRY
);
    // Core domain configuration and state
    logic [2:0] ctrl;
    logic [4:0] strobe_idx;
    logic [4:0] valid_idx;
    logic [31:0] code_mask;
    logic [4:0] code_shift;
    logic [9:0] tbl_addr;
    logic [15:0] tbl [0:TBL_DEPTH-1];
    logic [15:0] code_count;
    logic [9:0] last_codeword;
    logic cfg_tgl;
    logic rx_s1, rx_s2, rx_seen;
    logic [9:0] tx_hold;
    logic tx_tgl;
    // Link domain state
    logic lrst_s1, lrst_s2;
    logic cfg_s1, cfg_s2, cfg_seen;
    logic l_rx_en, l_tx_en;
    logic [4:0] l_strobe_idx, l_valid_idx, l_shift;
    logic [31:0] l_mask;
    logic [31:0] conn_s1, conn_s2;
    logic strobe_prev;
    logic slot_run;
    logic [9:0] rx_hold [0:1];
    logic rx_tgl;
    logic tx_s1, tx_s2, tx_seen;
    logic [$clog2(lpm_pkg::STROBE_HALF + 1)-1:0] div_cnt;
    logic strobe_q;

    // Decode helpers
    logic wr_ctrl, wr_pin, wr_mask, wr_shift, wr_taddr, wr_tdata;
    logic rx_evt, cfg_evt, tx_evt, strobe_now, valid_now, strobe_edge, capture;
    logic [9:0] rx_code_core;
    logic [31:0] masked;
    logic [9:0] next_codeword;
    assign wr_ctrl = I_WR && (I_ADDR == lpm_pkg::ADDR_CTRL);
    assign wr_pin = I_WR && (I_ADDR == lpm_pkg::ADDR_PIN_SEL);
    assign wr_mask = I_WR && (I_ADDR == lpm_pkg::ADDR_CODE_MASK);
    assign wr_shift = I_WR && (I_ADDR == lpm_pkg::ADDR_CODE_SHIFT);
    assign wr_taddr = I_WR && (I_ADDR == lpm_pkg::ADDR_TBL_ADDR);
    assign wr_tdata = I_WR && (I_ADDR == lpm_pkg::ADDR_TBL_DATA);
    assign rx_evt = rx_s2 ^ rx_seen;
    assign rx_code_core = rx_hold[rx_s2];

    // Link domain combinational sampling
    assign cfg_evt = cfg_s2 ^ cfg_seen;
    assign tx_evt = tx_s2 ^ tx_seen;
    assign strobe_now = conn_s2[l_strobe_idx];
    assign valid_now = conn_s2[l_valid_idx];
    assign strobe_edge = strobe_now ^ strobe_prev;
    assign capture = l_rx_en && strobe_edge && valid_now;
    assign masked = (conn_s2 & l_mask) >> l_shift;
    assign next_codeword = masked[lpm_pkg::CODEWORD_W-1:0];

    // Control and pin selection registers
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RSTN)
        begin
            ctrl <= lpm_pkg::CTRL_RST;
            strobe_idx <= lpm_pkg::STROBE_IDX_RST;
            valid_idx <= lpm_pkg::VALID_IDX_RST;
            code_mask <= lpm_pkg::CODE_MASK_RST;
            code_shift <= lpm_pkg::CODE_SHIFT_RST;
        end
        else
        begin
            if (wr_ctrl)
                ctrl <= I_WDATA[lpm_pkg::CTRL_W-1:0];
            if (wr_pin)
            begin
                strobe_idx <= I_WDATA[lpm_pkg::PIN_SEL_STROBE_LSB +: lpm_pkg::IDX_W];
                valid_idx <= I_WDATA[lpm_pkg::PIN_SEL_VALID_LSB +: lpm_pkg::IDX_W];
            end
            if (wr_mask)
                code_mask <= I_WDATA;
            if (wr_shift)
                code_shift <= I_WDATA[lpm_pkg::IDX_W-1:0];
        end
    end

    // Announce a configuration change to the link side
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RSTN)
            cfg_tgl <= 1'b0;
        else if (wr_ctrl || wr_pin || wr_mask || wr_shift)
            cfg_tgl <= ~cfg_tgl;
    end

    // Table address, auto increments after each data write
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RSTN)
            tbl_addr <= 10'h000;
        else if (wr_taddr)
            tbl_addr <= I_WDATA[lpm_pkg::CODEWORD_W-1:0];
        else if (wr_tdata)
            tbl_addr <= tbl_addr + 10'h001;
    end

    // Waveform table storage
    always_ff @(posedge I_CORE_CLK)
    begin
        if (wr_tdata)
            tbl[tbl_addr] <= I_WDATA[lpm_pkg::ENTRY_W-1:0];
    end

    // Read data, valid only in the cycle after the strobe
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RSTN || !I_RD)
            O_RDATA <= 32'h0000_0000;
        else
        begin
            case (I_ADDR)
                lpm_pkg::ADDR_CTRL: O_RDATA <= {29'h0000_0000, ctrl};
                lpm_pkg::ADDR_PIN_SEL: O_RDATA <= {19'h0_0000, valid_idx, 3'h0, strobe_idx};
                lpm_pkg::ADDR_CODE_MASK: O_RDATA <= code_mask;
                lpm_pkg::ADDR_CODE_SHIFT: O_RDATA <= {27'h000_0000, code_shift};
                lpm_pkg::ADDR_STATUS: O_RDATA <= {code_count, 6'h00, last_codeword};
                lpm_pkg::ADDR_TBL_ADDR: O_RDATA <= {22'h00_0000, tbl_addr};
                lpm_pkg::ADDR_TBL_DATA: O_RDATA <= {16'h0000, tbl[tbl_addr]};
                default: O_RDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Received codeword toggle synchroniser into the core
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RSTN)
        begin
            rx_s1 <= 1'b0;
            rx_s2 <= 1'b0;
            rx_seen <= 1'b0;
        end
        else
        begin
            rx_s1 <= rx_tgl;
            rx_s2 <= rx_s1;
            rx_seen <= rx_s2;
        end
    end

    // Codeword status and count
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RSTN)
        begin
            last_codeword <= 10'h000;
            code_count <= 16'h0000;
        end
        else if (rx_evt)
        begin
            last_codeword <= rx_code_core;
            code_count <= code_count + 16'h0001;
        end
    end

    // Indexed playback request from the table
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RSTN)
        begin
            O_WAVE_PLAY <= 1'b0;
            O_WAVE_INDEX <= 10'h000;
            O_WAVE_ENTRY <= 16'h0000;
        end
        else
        begin
            O_WAVE_PLAY <= rx_evt && ctrl[lpm_pkg::CTRL_PLAY_ARM];
            if (rx_evt && ctrl[lpm_pkg::CTRL_PLAY_ARM])
            begin
                O_WAVE_INDEX <= rx_code_core;
                O_WAVE_ENTRY <= tbl[rx_code_core];
            end
        end
    end

    // Readout result handed to the link side
    always_ff @(posedge I_CORE_CLK)
    begin
        if (!I_RSTN)
        begin
            tx_hold <= 10'h000;
            tx_tgl <= 1'b0;
        end
        else if (I_READOUT_VALID)
        begin
            tx_hold <= I_READOUT_RESULT;
            tx_tgl <= ~tx_tgl;
        end
    end

    // Reset synchroniser for the link domain
    always_ff @(posedge I_LINK_CLK)
    begin
        lrst_s1 <= I_RSTN;
        lrst_s2 <= lrst_s1;
    end

    // Cross-domain toggles and connector pins into the link domain
    always_ff @(posedge I_LINK_CLK)
    begin
        if (!lrst_s2)
        begin
            cfg_s1 <= 1'b0;
            cfg_s2 <= 1'b0;
            cfg_seen <= 1'b0;
            tx_s1 <= 1'b0;
            tx_s2 <= 1'b0;
            tx_seen <= 1'b0;
            conn_s1 <= 32'h0000_0000;
            conn_s2 <= 32'h0000_0000;
        end
        else
        begin
            cfg_s1 <= cfg_tgl;
            cfg_s2 <= cfg_s1;
            cfg_seen <= cfg_s2;
            tx_s1 <= tx_tgl;
            tx_s2 <= tx_s1;
            tx_seen <= tx_s2;
            conn_s1 <= I_CONN_IN;
            conn_s2 <= conn_s1;
        end
    end

    // Link copy of the configuration, loaded once the change is seen
    always_ff @(posedge I_LINK_CLK)
    begin
        if (!lrst_s2)
        begin
            l_rx_en <= 1'b0;
            l_tx_en <= 1'b0;
            l_strobe_idx <= lpm_pkg::STROBE_IDX_RST;
            l_valid_idx <= lpm_pkg::VALID_IDX_RST;
            l_mask <= lpm_pkg::CODE_MASK_RST;
            l_shift <= lpm_pkg::CODE_SHIFT_RST;
        end
        else if (cfg_evt)
        begin
            l_rx_en <= ctrl[lpm_pkg::CTRL_RX_EN];
            l_tx_en <= ctrl[lpm_pkg::CTRL_TX_EN];
            l_strobe_idx <= strobe_idx;
            l_valid_idx <= valid_idx;
            l_mask <= code_mask;
            l_shift <= code_shift;
        end
    end

    // Strobe edge capture into alternating slots
    always_ff @(posedge I_LINK_CLK)
    begin
        if (!lrst_s2)
        begin
            strobe_prev <= 1'b0;
            rx_tgl <= 1'b0;
            rx_hold[0] <= 10'h000;
            rx_hold[1] <= 10'h000;
        end
        else
        begin
            strobe_prev <= strobe_now;
            if (capture)
            begin
                rx_hold[~rx_tgl] <= next_codeword;
                rx_tgl <= ~rx_tgl;
            end
        end
    end

    // Previous strobe slot carried an accepted codeword
    always_ff @(posedge I_LINK_CLK)
    begin
        if (!lrst_s2)
            slot_run <= 1'b0;
        else if (strobe_edge)
            slot_run <= capture;
    end

    // Transmit strobe divider
    always_ff @(posedge I_LINK_CLK)
    begin
        if (!lrst_s2)
        begin
            div_cnt <= '0;
            strobe_q <= 1'b0;
        end
        else if (div_cnt == ($bits(div_cnt))'(lpm_pkg::STROBE_HALF - 1))
        begin
            div_cnt <= '0;
            strobe_q <= ~strobe_q;
        end
        else
            div_cnt <= div_cnt + 1'b1;
    end

    // Fixed transmit pin map
    always_ff @(posedge I_LINK_CLK)
    begin
        if (!lrst_s2)
        begin
            O_CONN_OUT <= 32'h0000_0000;
            O_CONN_OE <= 32'h0000_0000;
        end
        else
        begin
            O_CONN_OE <= l_tx_en ? lpm_pkg::TX_OE_MASK : 32'h0000_0000;
            O_CONN_OUT[lpm_pkg::PIN_VALID_A] <= tx_evt;
            O_CONN_OUT[lpm_pkg::PIN_VALID_B] <= tx_evt;
            if (tx_evt)
                O_CONN_OUT[lpm_pkg::PIN_RESULT_MSB:lpm_pkg::PIN_RESULT_LSB] <= tx_hold;
            O_CONN_OUT[lpm_pkg::PIN_RSV_MSB:lpm_pkg::PIN_RSV_LSB] <= 3'h0;
            O_CONN_OUT[lpm_pkg::PIN_STROBE] <= strobe_q;
            O_CONN_OUT[31:16] <= 16'h0000;
        end
    end

    // Checks on the link and core sides
    sequence s_capture;
        capture;
    endsequence
    sequence s_back_to_back;
        slot_run && capture;
    endsequence

    a_strobe_select: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_s2)
        cfg_evt |=> (l_strobe_idx == $past(strobe_idx)) && (l_valid_idx == $past(valid_idx)))
        else $error("link strobe or valid index not loaded");
    a_field_extract: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_s2)
        s_capture |=> rx_hold[rx_tgl] == $past(10'(((conn_s2 & l_mask) >> l_shift))))
        else $error("captured codeword differs from masked shifted word");
    a_play_index: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
        (rx_evt && ctrl[lpm_pkg::CTRL_PLAY_ARM]) |=> O_WAVE_PLAY && (O_WAVE_INDEX == $past(rx_code_core)))
        else $error("playback index not taken from codeword");
    a_no_play_idle: assert property (@(posedge I_CORE_CLK) disable iff (!I_RSTN)
        !rx_evt |=> !O_WAVE_PLAY)
        else $error("playback request without codeword");
    a_tx_outputs: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_s2)
        l_tx_en |=> (O_CONN_OE == lpm_pkg::TX_OE_MASK))
        else $error("transmit pins not all driven");
    a_valid_pins: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_s2)
        tx_evt |=> O_CONN_OUT[lpm_pkg::PIN_VALID_A] && O_CONN_OUT[lpm_pkg::PIN_VALID_B] ##1
        (O_CONN_OUT[lpm_pkg::PIN_VALID_A] == O_CONN_OUT[lpm_pkg::PIN_VALID_B]))
        else $error("valid flag copies disagree");
    a_result_pins: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_s2)
        tx_evt |=> O_CONN_OUT[lpm_pkg::PIN_RESULT_MSB:lpm_pkg::PIN_RESULT_LSB] == $past(tx_hold))
        else $error("readout results not on result pins");
    a_reserved_low: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_s2)
        ##1 O_CONN_OUT[lpm_pkg::PIN_RSV_MSB:lpm_pkg::PIN_RSV_LSB] == 3'h0)
        else $error("reserved pins not low");
    a_strobe_toggle: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_s2)
        (div_cnt == ($bits(div_cnt))'(lpm_pkg::STROBE_HALF - 1)) |=> ##1
        (O_CONN_OUT[lpm_pkg::PIN_STROBE] != $past(O_CONN_OUT[lpm_pkg::PIN_STROBE])))
        else $error("strobe pin did not toggle");
    a_back_to_back: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_s2)
        s_back_to_back |=> (rx_tgl != $past(rx_tgl)) && (rx_hold[rx_tgl] == $past(next_codeword)))
        else $error("back to back codeword lost");
    a_ignore_invalid: assert property (@(posedge I_LINK_CLK) disable iff (!lrst_s2)
        (strobe_edge && !valid_now) |=> $stable(rx_tgl))
        else $error("codeword taken in invalid slot");
endmodule
`default_nettype wire

// [tb/lpm_ctrl_model.sv]
// Control unit model sending codewords on the connector input pins
`timescale 1ns/10ps
`default_nettype none
module lpm_ctrl_model
(
    // Link clock
    input wire logic i_link_clk,
    // Pin placement chosen by the bench
    input wire logic [4:0] i_strobe_idx,
    input wire logic [4:0] i_valid_idx,
    input wire logic [4:0] i_shift,
    // Connector levels toward the block
    output logic [31:0] o_pins
);
    localparam int SLOT = 5;
    logic [9:0] cw_q[$];
    logic strobe = 1'b0;
    logic valid = 1'b0;
    logic [9:0] cw = 10'h000;
    logic [31:0] junk = 32'h0000_0000;
    int cnt = 0;

    // Queue a codeword for the next free slot
    task automatic send(input logic [9:0] c);
        cw_q.push_back(c);
    endtask

    // Fixed slot grid, one strobe transition per slot
    always @(posedge i_link_clk)
    begin
        junk <= $urandom;
        cnt <= (cnt == SLOT - 1) ? 0 : cnt + 1;
        if (cnt == SLOT - 1)
        begin
            strobe <= ~strobe;
            valid <= (cw_q.size() != 0);
            cw <= (cw_q.size() != 0) ? cw_q.pop_front() : 10'h000;
        end
    end

    // Codeword field carries noise whenever valid is low
    always_comb
    begin
        o_pins = junk;
        if (valid)
            o_pins = (junk & ~(32'h0000_03ff << i_shift)) | (32'(cw) << i_shift);
        o_pins[i_strobe_idx] = strobe;
        o_pins[i_valid_idx] = valid;
    end
endmodule
`default_nettype wire

// [tb/lpm_top_tb.sv]
// Self-checking bench for the codeword link pin mapping block
`timescale 1ns/10ps
`default_nettype none
module lpm_top_tb;
    logic clk = 1'b0;
    logic link_clk = 1'b0;
    logic rstn = 1'b0;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0000_0000;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic rd_d = 1'b0;
    logic ro_valid = 1'b0;
    logic [9:0] ro_res = 10'h000;
    logic [31:0] rdata, conn_in, conn_out, conn_oe;
    logic play;
    logic [9:0] wave_idx, cw;
    logic [15:0] wave_entry, entry;
    logic [4:0] m_strobe = 5'h0f;
    logic [4:0] m_valid = 5'h00;
    logic [4:0] m_shift = 5'h01;
    logic s15 = 1'b0;
    logic tx_on = 1'b0;
    logic [31:0] rd_q[$], play_q[$], tx_q[$];
    logic [4:0] cs[2] = '{5'h0f, 5'h05};
    logic [4:0] cv[2] = '{5'h00, 5'h03};
    logic [4:0] csh[2] = '{5'h01, 5'h16};
    int fails = 0;
    int checks_done = 0;
    int total = 0;
    int r;

    // Core and link clocks, unrelated in phase
    initial forever #12.5 clk = ~clk;
    initial
    begin
        #7;
        forever #16 link_clk = ~link_clk;
    end

    lpm_top u_lpm_top (.I_CORE_CLK(clk), .I_RSTN(rstn), .I_LINK_CLK(link_clk), .I_ADDR(addr),
        .I_WDATA(wdata), .I_WR(wr_s), .I_RD(rd_s), .O_RDATA(rdata), .I_CONN_IN(conn_in),
        .O_CONN_OUT(conn_out), .O_CONN_OE(conn_oe), .I_READOUT_VALID(ro_valid),
        .I_READOUT_RESULT(ro_res), .O_WAVE_PLAY(play), .O_WAVE_INDEX(wave_idx),
        .O_WAVE_ENTRY(wave_entry));

    lpm_ctrl_model u_lpm_ctrl_model (.i_link_clk(link_clk), .i_strobe_idx(m_strobe),
        .i_valid_idx(m_valid), .i_shift(m_shift), .o_pins(conn_in));

    // Result bookkeeping
    task automatic report(input bit ok, input string m);
        checks_done++;
        if (!ok)
        begin
            fails++;
            $display("[ERR] %0t %s", $time, m);
        end
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        report(got === exp, "register read mismatch");
    endtask
    task automatic chk_play(input logic [31:0] got, input logic [31:0] exp);
        report(got === exp, "playback request mismatch");
    endtask
    task automatic chk_tx(input logic [31:0] got, input logic [31:0] exp);
        report(got === exp, "transmit pins mismatch");
    endtask

    // Register port cycles
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wr_s <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr_s <= 1'b0;
        @(posedge clk);
        // Config rewrites need four core cycles to reach the link side
        repeat (4) @(posedge clk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        rd_q.push_back(exp);
        rd_s <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd_s <= 1'b0;
        @(posedge clk);
    endtask

    task automatic end_of_test();
        $display("checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    // Read data monitor, one cycle after the strobe
    always @(posedge clk)
    begin
        rd_d <= rd_s;
        if (rd_d === 1'b1)
            chk_reg(rdata, rd_q.pop_front());
    end

    // Playback monitor
    always @(posedge clk)
        if (play === 1'b1)
        begin
            if (play_q.size() == 0)
                report(1'b0, "unexpected playback");
            else
                chk_play({wave_entry, 6'h00, wave_idx}, play_q.pop_front());
        end

    // Transmit pin monitor in the link domain
    always @(posedge link_clk)
    begin
        s15 <= conn_out[15];
        if (tx_on)
            chk_tx({31'h0, conn_out[15]}, {31'h0, ~s15});
        if (conn_out[0] === 1'b1)
        begin
            if (tx_q.size() == 0)
                report(1'b0, "unexpected transmit valid");
            else
                chk_tx(conn_out & 32'hffff_7fff, tx_q.pop_front());
            chk_tx(conn_oe, 32'h0000_ffff);
        end
    end

    // Watchdog
    initial
    begin
        #300000;
        fails++;
        end_of_test();
    end

    // Main sequence
    initial
    begin
        void'($urandom(80030));
        repeat (5) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        chk_reg(conn_oe, 32'h0000_0000);
        rd(lpm_pkg::ADDR_CTRL, 32'h0000_0000);
        rd(lpm_pkg::ADDR_PIN_SEL, 32'h0000_000f);
        rd(lpm_pkg::ADDR_CODE_MASK, 32'h0000_07fe);
        rd(lpm_pkg::ADDR_CODE_SHIFT, 32'h0000_0001);
        rd(8'h40, 32'h0000_0000);
        for (int c = 0; c < 2; c++)
        begin
            wr(lpm_pkg::ADDR_CTRL, 32'h0000_0002);
            wr(lpm_pkg::ADDR_PIN_SEL, {19'h0, cv[c], 3'h0, cs[c]});
            wr(lpm_pkg::ADDR_CODE_MASK, 32'h0000_03ff << csh[c]);
            wr(lpm_pkg::ADDR_CODE_SHIFT, {27'h0, csh[c]});
            m_strobe <= cs[c];
            m_valid <= cv[c];
            m_shift <= csh[c];
            repeat (12) @(posedge clk);
            wr(lpm_pkg::ADDR_CTRL, 32'h0000_0007);
            r = $urandom;
            for (int k = 0; k < 4; k++)
            begin
                cw = (k == 3) ? 10'h3ff : (10'(r + k * 257) & 10'h3fe);
                entry = 16'($urandom);
                wr(lpm_pkg::ADDR_TBL_ADDR, {22'h0, cw});
                wr(lpm_pkg::ADDR_TBL_DATA, {16'h0, entry});
                play_q.push_back({entry, 6'h00, cw});
            end
            rd(lpm_pkg::ADDR_PIN_SEL, {19'h0, cv[c], 3'h0, cs[c]});
            rd(lpm_pkg::ADDR_TBL_ADDR, 32'h0000_0000);
            wr(lpm_pkg::ADDR_TBL_ADDR, {22'h0, cw});
            rd(lpm_pkg::ADDR_TBL_DATA, {16'h0, entry});
            for (int k = 0; k < 4; k++)
                u_lpm_ctrl_model.send(play_q[k][9:0]);
            repeat (80) @(posedge clk);
            total += 4;
            rd(lpm_pkg::ADDR_STATUS, {16'(total), 6'h00, 10'h3ff});
            // Receive on, playback disarmed: counted but never played
            wr(lpm_pkg::ADDR_CTRL, 32'h0000_0003);
            u_lpm_ctrl_model.send(10'h2aa);
            repeat (40) @(posedge clk);
            total += 1;
            rd(lpm_pkg::ADDR_STATUS, {16'(total), 6'h00, 10'h2aa});
            wr(lpm_pkg::ADDR_CTRL, 32'h0000_0006);
            u_lpm_ctrl_model.send(10'h155);
            repeat (40) @(posedge clk);
            rd(lpm_pkg::ADDR_STATUS, {16'(total), 6'h00, 10'h2aa});
        end
        tx_on <= 1'b1;
        for (int i = 0; i < 6; i++)
        begin
            ro_res <= (i == 0) ? 10'h3ff : 10'($urandom);
            ro_valid <= 1'b1;
            @(posedge clk);
            tx_q.push_back(32'h0000_4001 | (32'(ro_res) << 1));
            ro_valid <= 1'b0;
            repeat (7) @(posedge clk);
        end
        repeat (20) @(posedge clk);
        report(play_q.size() == 0 && tx_q.size() == 0, "results missing");
        end_of_test();
    end
endmodule
`default_nettype wire
